// >>> design/chip_reset_seq.sv
// Purpose: chip reset sequencing and pin state control during reset
// Assumes: clk_sys is the internal clock T; tck, tms, chip_reset_n, first_interrupt_input are pins
// Notes: pin groups use output and enable pairs; the wire is resolved outside
`timescale 1ns/1ps
// How it works
// - power-up reset clears the test-port controller without outside help
// - reset plus first interrupt: all outputs high impedance, test output excepted
// - reset alone: memory, io, select, strobe held high, clock output runs
// - slow clock select gives clock output period between 0.74 and 3.8 us
// - clock output period follows internal clock, from input clock or pll
module chip_reset_seq #(
  parameter int unsigned SLOW_HALF = rst_seq_pkg::SLOW_HALF_CYC
) (
  input wire logic clk_sys, // internal clock T
  input wire logic arst_n, // power-up reset, active low
  input wire logic chip_reset_n, // chip reset pin, active low
  input wire logic first_interrupt_input, // first interrupt pin, active high
  input wire logic tck, // test clock pin
  input wire logic tms, // test mode select pin
  input wire logic slow_clock_select, // slow clock option bit
  input wire logic core_ext_program_enable, // core request, active low
  input wire logic core_ext_ram_high_enable, // core request, active low
  input wire logic core_ext_ram_low_enable, // core request, active low
  input wire logic core_io_enable, // core request, active low
  input wire logic core_device_select_out, // core request
  input wire logic core_read_write_strobe, // core request
  input wire logic core_other_oe, // core enable for remaining pins
  output logic ext_program_enable, // memory enable out
  output logic ext_ram_high_enable, // memory enable out
  output logic ext_ram_low_enable, // memory enable out
  output logic io_enable, // io enable out
  output logic device_select_out, // select out
  output logic read_write_strobe, // strobe out
  output logic ctrl_pins_oe, // enable for the six control pins
  output logic other_pins_oe, // enable for other outputs and bidirectionals
  output logic clock_output_pin, // clock output level
  output logic clock_output_oe, // clock output enable
  output logic core_reset_n, // synchronised core reset, active low
  output logic tap_reset, // test controller held in reset
  output logic reset_too_short // pulse: chip reset shorter than six periods
);
  typedef enum logic [1:0] {TAP_RST = 2'b00, TAP_RUN = 2'b01} tap_state_t;

  rst_sync_if rst_s ();
  rst_sync_if int_s ();
  rst_sync_if tck_s ();
  rst_sync_if tms_s ();

  // chip reset syncs to low, so power-up starts with the core held
  pin_sync #(.RESET_VAL(1'b0)) u_rst (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin(chip_reset_n),
    .out(rst_s)
  );
  pin_sync #(.RESET_VAL(1'b0)) u_int (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin(first_interrupt_input),
    .out(int_s)
  );
  pin_sync #(.RESET_VAL(1'b0)) u_tck (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin(tck),
    .out(tck_s)
  );
  // tms idles high through its pull-up, so it resets high to avoid a false edge
  pin_sync #(.RESET_VAL(1'b1)) u_tms (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pin(tms),
    .out(tms_s)
  );

  tap_state_t tap_q;
  logic [2:0] tms_cnt_q;
  logic [1:0] rel_q;
  logic [3:0] low_cnt_q;
  logic [7:0] slow_cnt_q;
  logic slow_clk_q;
  logic in_reset;
  logic tri_all;
  logic hold_pins;

  // power-up reset starts the test controller in reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tap_q <= TAP_RST;
    end else if (tck_s.rise) begin
      if (!tms_s.level) begin
        tap_q <= TAP_RUN;
      end else if (tms_cnt_q == 3'(rst_seq_pkg::TAP_RESET_EDGES - 1)) begin
        tap_q <= TAP_RST;
      end
    end
  end

  // rises with tms high are counted; the count saturates, so every later rise keeps reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tms_cnt_q <= 3'h0;
    end else if (tck_s.rise) begin
      if (!tms_s.level) begin
        tms_cnt_q <= 3'h0;
      end else if (tms_cnt_q != 3'(rst_seq_pkg::TAP_RESET_EDGES - 1)) begin
        tms_cnt_q <= tms_cnt_q + 3'h1;
      end
    end
  end

  assign tap_reset = (tap_q == TAP_RST);

  // release is delayed two edges so every core flop leaves reset together
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rel_q <= rst_seq_pkg::RST_SYNC_RESET;
    end else if (!rst_s.level) begin
      rel_q <= rst_seq_pkg::RST_SYNC_RESET;
    end else begin
      rel_q <= {rel_q[0], 1'b1};
    end
  end

  assign core_reset_n = rel_q[1];
  assign in_reset = !rst_s.level;
  assign tri_all = in_reset && int_s.level;
  assign hold_pins = in_reset || !core_reset_n;

  // length of the synced low pulse; saturates so a long reset never wraps to short
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_q <= 4'h0;
    end else if (!rst_s.level) begin
      if (low_cnt_q != 4'hf) begin
        low_cnt_q <= low_cnt_q + 4'h1;
      end
    end else begin
      low_cnt_q <= 4'h0;
    end
  end

  // the rise cycle is still low, so it counts as the last period of the pulse;
  // a short pulse is only flagged, the reset still acts
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reset_too_short <= 1'b0;
    end else begin
      reset_too_short <= rst_s.rise && (low_cnt_q < 4'(rst_seq_pkg::RESET_MIN_PERIODS - 1));
    end
  end

  // slow clock divider runs always, so its rate is steady when the select flips;
  // half periods above 256 cycles would need a wider counter
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      slow_cnt_q <= 8'h0;
    end else if (slow_cnt_q == 8'(SLOW_HALF - 1)) begin
      slow_cnt_q <= 8'h0;
    end else begin
      slow_cnt_q <= slow_cnt_q + 8'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      slow_clk_q <= 1'b0;
    end else if (slow_cnt_q == 8'(SLOW_HALF - 1)) begin
      slow_clk_q <= !slow_clk_q;
    end
  end

  // normal clock output is the internal clock itself, period T;
  // the select switch is not glitch free, the first half period after a flip may be short
  assign clock_output_pin = slow_clock_select ? slow_clk_q : clk_sys;
  assign clock_output_oe = !tri_all;

  // memory enables held high while the core is in reset; core requests are refused then
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ext_program_enable <= 1'b1;
      ext_ram_high_enable <= 1'b1;
      ext_ram_low_enable <= 1'b1;
    end else if (hold_pins) begin
      ext_program_enable <= 1'b1;
      ext_ram_high_enable <= 1'b1;
      ext_ram_low_enable <= 1'b1;
    end else begin
      ext_program_enable <= core_ext_program_enable;
      ext_ram_high_enable <= core_ext_ram_high_enable;
      ext_ram_low_enable <= core_ext_ram_low_enable;
    end
  end

  // io enable, select and strobe share the same hold
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      io_enable <= 1'b1;
      device_select_out <= 1'b1;
      read_write_strobe <= 1'b1;
    end else if (hold_pins) begin
      io_enable <= 1'b1;
      device_select_out <= 1'b1;
      read_write_strobe <= 1'b1;
    end else begin
      io_enable <= core_io_enable;
      device_select_out <= core_device_select_out;
      read_write_strobe <= core_read_write_strobe;
    end
  end

  assign ctrl_pins_oe = !tri_all;
  assign other_pins_oe = !tri_all && core_other_oe;
endmodule

// >>> include/rst_seq_pkg.sv
// Purpose: shared constants for the chip reset sequencer
// Assumes: system clock at 50 MHz
// Notes: times kept in their printed unit, cycle counts derived
package rst_seq_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // test-port reset: tck rising edges with tms held high
  localparam int unsigned TAP_RESET_EDGES = 6;
  // least chip reset pulse, in internal clock periods
  localparam int unsigned RESET_MIN_PERIODS = 6;
  // slow clock output period window, in ns
  localparam int unsigned SLOW_PERIOD_MIN_NS = 740;
  localparam int unsigned SLOW_PERIOD_MAX_NS = 3800;
  // half period counts; least rounds up, longest rounds down
  localparam int unsigned SLOW_HALF_MIN_CYC = (SLOW_PERIOD_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLOW_HALF_MAX_CYC = (SLOW_PERIOD_MAX_NS / 2) / CLK_PERIOD_NS;
  // chosen slow half period: 40 cycles gives 1.6 us
  localparam int unsigned SLOW_HALF_CYC = 40;
  localparam logic [1:0] RST_SYNC_RESET = 2'h0;
endpackage

// >>> include/rst_sync_if.sv
// Purpose: carries one synchronised pin level between sequencer modules
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
interface rst_sync_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// >>> design/pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: pin is asynchronous to clk_sys
// Notes: first stage read only by the second
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic pin, // raw pin
  rst_sync_if.src out // filtered level and edges
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lvl_q <= RESET_VAL;
    end else if (s2_q == s3_q) begin
      lvl_q <= s3_q;
    end
  end

  assign out.level = lvl_q;
  assign out.rise = (s2_q == s3_q) && s3_q && !lvl_q;
  assign out.fall = (s2_q == s3_q) && !s3_q && lvl_q;
endmodule

// >>> tb/chip_reset_seq_properties.sv
// Purpose: port properties of chip_reset_seq
// Assumes: one clock, clk_sys
// Notes: slow clock is measured only after two toggles, the mux switch can look like one
`timescale 1ns/1ps
module seq_props #(
  parameter int unsigned SLOW_HALF = 40
) (
  input wire logic clk_sys, arst_n, chip_reset_n, first_interrupt_input, tms, slow_clock_select, // pins
  input wire logic ext_program_enable, ext_ram_high_enable, ext_ram_low_enable, io_enable, // enables
  input wire logic device_select_out, read_write_strobe, ctrl_pins_oe, other_pins_oe, // select, oe
  input wire logic core_ext_program_enable, core_ext_ram_high_enable, core_ext_ram_low_enable, // core requests
  input wire logic core_io_enable, core_device_select_out, core_read_write_strobe, // core requests
  input wire logic clock_output_pin, clock_output_oe, core_reset_n, tap_reset, reset_too_short // status
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic [7:0] half_q;
  logic [1:0] seen_q;
  wire hi = ext_program_enable & ext_ram_high_enable & ext_ram_low_enable & io_enable
    & device_select_out & read_write_strobe;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) half_q <= 8'h00;
    else if ($changed(clock_output_pin)) half_q <= 8'h00;
    else half_q <= half_q + 8'h01;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) seen_q <= 2'h0;
    else if (!slow_clock_select) seen_q <= 2'h0;
    else if ($changed(clock_output_pin) && seen_q != 2'h2) seen_q <= seen_q + 2'h1;
  end
  hold_high_a: assert property (!core_reset_n && !$past(core_reset_n) |-> hi) else $error("enables low in reset");
  tri_all_a: assert property ((!chip_reset_n && first_interrupt_input) [*6]
    |-> !ctrl_pins_oe && !other_pins_oe && !clock_output_oe) else $error("pins driven in reset with interrupt");
  reset_alone_a: assert property ((!chip_reset_n && !first_interrupt_input) [*6]
    |-> ctrl_pins_oe && clock_output_oe && hi) else $error("pins wrong in plain reset");
  core_hold_a: assert property (!chip_reset_n [*6] |-> !core_reset_n) else $error("core left reset early");
  pulse_once_a: assert property (reset_too_short |=> !reset_too_short) else $error("short flag too long");
  long_ok_a: assert property (!chip_reset_n [*8] ##1 chip_reset_n |-> !reset_too_short [*6])
    else $error("long reset flagged short");
  slow_half_a: assert property (slow_clock_select && seen_q == 2'h2 && $changed(clock_output_pin)
    |-> half_q == SLOW_HALF - 1) else $error("slow clock half period wrong");
  tap_leave_a: assert property ($fell(tap_reset) |-> !tms) else $error("test reset left with tms high");
  follow_core_a: assert property (core_reset_n && $past(core_reset_n) |->
    ext_program_enable == $past(core_ext_program_enable) && ext_ram_high_enable == $past(core_ext_ram_high_enable)
    && ext_ram_low_enable == $past(core_ext_ram_low_enable) && io_enable == $past(core_io_enable)
    && device_select_out == $past(core_device_select_out) && read_write_strobe == $past(core_read_write_strobe))
    else $error("enables do not follow the core");
endmodule
bind chip_reset_seq seq_props #(.SLOW_HALF(SLOW_HALF)) props (.*);

// >>> tb/board_partner.sv
// Purpose: board reset controller and test-port host
// Assumes: called just after a clk_sys edge
// Notes: tck stands still between bursts; tms idles high as its pull-up
`timescale 1ns/1ps
module board_partner (
  input wire logic clk_sys, // internal clock
  output logic chip_reset_n, // chip reset drive
  output logic tck, // test clock drive
  output logic tms // test mode drive
);
  initial begin
    chip_reset_n = 1'b0;
    tck = 1'b0;
    tms = 1'b1;
  end
  // four clocks a half keeps each level past the three-stage sampler
  task automatic tck_rises(input int n, input logic mode);
    @(posedge clk_sys);
    tms <= mode;
    repeat (n) begin
      repeat (4) @(posedge clk_sys);
      tck <= 1'b1;
      repeat (4) @(posedge clk_sys);
      tck <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
    tms <= 1'b1;
  endtask
  // clock keeps running through the low time
  task automatic chip_pulse(input int low_cyc);
    @(posedge clk_sys);
    chip_reset_n <= 1'b0;
    repeat (low_cyc) @(posedge clk_sys);
    chip_reset_n <= 1'b1;
  endtask
endmodule

// >>> tb/testbench.sv
// Purpose: self-checking bench for chip_reset_seq
// Assumes: board model drives chip reset and test port
// Notes: core requests change randomly every cycle
`timescale 1ns/1ps
module testbench;
  logic clk_sys, arst_n, first_interrupt_input, slow_clock_select, flag_seen, prev_run, chip_reset_n, tck, tms;
  logic core_ext_program_enable, core_ext_ram_high_enable, core_ext_ram_low_enable, core_io_enable;
  logic core_device_select_out, core_read_write_strobe, core_other_oe, ext_program_enable, ext_ram_high_enable;
  logic ext_ram_low_enable, io_enable, device_select_out, read_write_strobe, ctrl_pins_oe, other_pins_oe;
  logic clock_output_pin, clock_output_oe, core_reset_n, tap_reset, reset_too_short;
  logic [6:0] core_v;
  int mismatches, total_checks;
  int half_n, edge_n, slow_ns;
  logic slow_lvl, slow_ok;
  wire all_high = ext_program_enable & ext_ram_high_enable & ext_ram_low_enable & io_enable
    & device_select_out & read_write_strobe;
  logic exp_q[$];
  int lens[$] = '{5, 6, 3, 9};
  assign {core_ext_program_enable, core_ext_ram_high_enable, core_ext_ram_low_enable, core_io_enable,
    core_device_select_out, core_read_write_strobe, core_other_oe} = core_v;
  chip_reset_seq dut (.*);
  board_partner board (.*);
  // 50 MHz internal clock stays within the direct-clock range, no pll needed
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) core_v <= 7'($urandom);
  task automatic check(input string what, input logic seen, input logic exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %b, seen %b", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_run();
    int n;
    // let the synced pin reach the core reset before looking at it
    repeat (6) @(posedge clk_sys);
    n = 0;
    while (core_reset_n !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 50) begin
      mismatches++;
      $display("unexpected core_reset_n: expected 1, seen %b", core_reset_n);
      results();
    end
    repeat (12) @(posedge clk_sys);
  endtask
  // every release of the core is one result: was the short flag raised before it
  always @(posedge clk_sys) begin
    if (reset_too_short === 1'b1) flag_seen = 1'b1;
    if (core_reset_n === 1'b1 && prev_run === 1'b0 && exp_q.size() > 0) begin
      check("reset_too_short", flag_seen, exp_q.pop_front());
      flag_seen = 1'b0;
    end
    prev_run = core_reset_n;
  end
  initial begin
    {arst_n, first_interrupt_input, slow_clock_select, flag_seen, prev_run} = 5'h00;
    core_v = 7'h00;
    mismatches = 0;
    total_checks = 0;
    void'($urandom(32'h7471));
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (2) @(negedge clk_sys);
    check("tap_reset", tap_reset, 1'b1);
    $display("test power_up done");
    board.tck_rises(1, 1'b0);
    @(negedge clk_sys) check("tap_reset", tap_reset, 1'b0);
    board.tck_rises(5, 1'b1);
    @(negedge clk_sys) check("tap_reset", tap_reset, 1'b0);
    board.tck_rises(1, 1'b1);
    @(negedge clk_sys) check("tap_reset", tap_reset, 1'b1);
    $display("test tap done");
    exp_q.push_back(1'b0);
    board.chip_pulse(10);
    wait_run();
    lens.push_back(3 + ($urandom % 8));
    foreach (lens[i]) begin
      exp_q.push_back(lens[i] < rst_seq_pkg::RESET_MIN_PERIODS);
      board.chip_pulse(lens[i]);
      wait_run();
    end
    $display("test pulses done");
    for (int m = 1; m >= 0; m--) begin
      first_interrupt_input <= m[0];
      exp_q.push_back(1'b0);
      fork
        board.chip_pulse(16);
        begin
          repeat (10) @(negedge clk_sys);
          #2;
          check("ctrl_pins_oe", ctrl_pins_oe, !m[0]);
          check("other_pins_oe", other_pins_oe, !m[0] && core_other_oe);
          check("clock_output_oe", clock_output_oe, !m[0]);
          check("clock_output_pin", clock_output_pin, 1'b0);
          check("enables", all_high, 1'b1);
        end
      join
      wait_run();
    end
    $display("test pins done");
    slow_clock_select <= 1'b1;
    @(negedge clk_sys);
    slow_lvl = clock_output_pin;
    half_n = 0;
    edge_n = 0;
    // one full half period lies between the first and the second change
    for (int c = 0; c < 400 && edge_n < 2; c++) begin
      @(negedge clk_sys);
      half_n++;
      if (clock_output_pin !== slow_lvl) begin
        slow_lvl = clock_output_pin;
        edge_n++;
        if (edge_n == 1) half_n = 0;
      end
    end
    slow_ns = 2 * half_n * rst_seq_pkg::CLK_PERIOD_NS;
    slow_ok = (edge_n == 2) && (slow_ns >= rst_seq_pkg::SLOW_PERIOD_MIN_NS);
    check("slow_period_ok", slow_ok && (slow_ns <= rst_seq_pkg::SLOW_PERIOD_MAX_NS), 1'b1);
    repeat (200) @(posedge clk_sys);
    slow_clock_select <= 1'b0;
    $display("test slow done");
    results();
  end
endmodule
